// [inc/cspt_defs.vh]
// Constants for the clock source, PLL and tuning control block.
// Assumes inclusion by the design files under hdl/; definitions only.
`ifndef CSPT_DEFS_VH
`define CSPT_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the Wishbone slave)
// ----------------------------------------------------------------
`define CSPT_TUNE_IDX      12'hF9B
`define CSPT_ADDR_TUNE     14'h3E6C
`define CSPT_ADDR_CTRL     14'h3E70
`define CSPT_ADDR_STAT     14'h3E74
`define CSPT_AW            14

// ----------------------------------------------------------------
// Tuning register fields
// ----------------------------------------------------------------
`define CSPT_TUNE_RST      8'h00
`define CSPT_BIT_LFSRC     7
`define CSPT_BIT_PLL_ENABLE_BIT     6
`define CSPT_TUNE_MAX      6'h1F
`define CSPT_TUNE_MIN      6'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CSPT_CTRL_RST      8'h60
`define CSPT_SCS_LSB       0
`define CSPT_INTERNAL_FREQ_SELECT_LSB      4
`define CSPT_INTERNAL_FREQ_SELECT_31K      3'h0
`define CSPT_INTERNAL_FREQ_SELECT_4M       3'h6
`define CSPT_INTERNAL_FREQ_SELECT_8M       3'h7

// ----------------------------------------------------------------
// Oscillator modes and source selects
// ----------------------------------------------------------------
`define CSPT_MODE_EXTERNAL_CLOCK_MODE_WITH_PLL    3'h7
`define CSPT_MODE_EC       3'h6
`define CSPT_MODE_CRYSTAL_MODE_WITH_PLL    3'h5
`define CSPT_MODE_HS       3'h4
`define CSPT_MODE_IOPLLO   3'h3
`define CSPT_MODE_IOPLL    3'h2
`define CSPT_MODE_IOO      3'h1
`define CSPT_MODE_IO       3'h0
`define CSPT_SCS_PRI       2'h0
`define CSPT_SCS_SEC       2'h1

// ----------------------------------------------------------------
// Timing and dividers
// ----------------------------------------------------------------
`define CSPT_LOCK_US       2000
`define CSPT_CLK_MHZ       100
`define CSPT_DIV256        8'hFF
`define CSPT_OSC_OUT_DIV   2'h3

`endif

// [hdl/cspt_clkdiv.v]
// Glitch-free integer divider: ratio in 1..max, phases stay whole.
// Assumes a single free-running source clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module cspt_clkdiv #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] ratio_m1,
  output reg          tick
);

  reg [W-1:0] cnt;

  // ----------------------------------------------------------------
  // Counter; ratio is compared every cycle, so a change applies within the current period
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      cnt  <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt >= ratio_m1) begin
      cnt  <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [hdl/cspt_top.v]
// Clock source selection, PLL control, core divider and tuning register.
// Assumes oscillators arrive as enable ticks on clk; config bits static.
//
// Behaviour
// - Core clock is selected source divided by one, two, three or six; PLL output by two, four, six or twelve.
// - External clock modes run at once, no start-up wait.
// - External clock without PLL: output pin toggles at input over four.
// - External clock with PLL: output pin carries PLL output over four.
// - PLL runs only in PLL-capable mode with enable bit six set.
// - PLL takes 4 MHz reference and gives fixed 96 MHz.
// - Eight prescale ratios bring multiples of 4 MHz to reference.
// - Internal 8 MHz output clocks device and feeds postscaler.
// - RC oscillator runs when selected or any dependent feature enabled.
// - Frequency select picks 8 MHz direct, RC direct or postscaled.
// - Tuning write shifts frequency, execution continues, no done flag.
// - Non-PLL modes keep PLL off whatever the enable bit says.
// - PLL enable keeps bypass clock until lock, then switches itself.
// - Tuning field bits five to zero, signed, 011111 max, 100000 min.
// - Tuning value reaches only the 8 MHz oscillator.
// - Source select bits clear on every reset.
// - Postscaler selects 4 MHz after reset.
// - Select value 000 means 31 kHz, source from bit seven.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "cspt_defs.vh"

module cspt_top #(
  parameter LOCK_CYCLES = (`CSPT_LOCK_US * `CSPT_CLK_MHZ)
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [13:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_stb_i,
  input  wire        wb_cyc_i,
  output reg         wb_ack_o,
  input  wire [2:0]  osc_mode_cfg,
  input  wire [2:0]  pll_prescale_cfg,
  input  wire [1:0]  core_clock_divider_cfg,
  input  wire        pwrt_en,
  input  wire        fscm_en,
  input  wire        wdt_en,
  input  wire        two_speed_en,
  input  wire        oscillator_input_pin,
  input  wire        osc_8m_tick,
  input  wire        rc_31k_tick,
  input  wire        sec_osc_tick,
  input  wire        pll_96m_tick,
  input  wire        pll_locked,
  output reg         oscillator_output_pin,
  output reg         oscillator_output_oe,
  output reg         core_clk_en,
  output reg         pll_run,
  output reg         pll_ref_tick,
  output reg         rc_osc_run,
  output reg         osc_8m_run,
  output reg  [5:0]  osc_8m_trim,
  output reg         ext_clock_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ST_BYPASS = 3'b001;
  localparam ST_LOCK   = 3'b010;
  localparam ST_PLL    = 3'b100;

  reg  [7:0]  oscillator_tuning;
  reg  [7:0]  clock_ctrl;
  reg  [2:0]  pll_state;
  reg  [2:0]  next_pll_state;
  reg  [31:0] lock_cnt;
  reg  [1:0]  out_cnt;
  reg         src_tick;
  reg         post_tick;
  reg         pll_sel;
  reg  [1:0]  scs_act;
  reg  [7:0]  core_ratio;
  wire        core_tick;
  wire        wb_req;
  wire        wr_stb;

  wire [1:0] system_clock_source_select       = clock_ctrl[`CSPT_SCS_LSB+1:`CSPT_SCS_LSB];
  wire [2:0] internal_freq_select      = clock_ctrl[`CSPT_INTERNAL_FREQ_SELECT_LSB+2:`CSPT_INTERNAL_FREQ_SELECT_LSB];
  wire       lfsrc     = oscillator_tuning[`CSPT_BIT_LFSRC];
  wire       pll_bit   = oscillator_tuning[`CSPT_BIT_PLL_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function pll_capable;
    input [2:0] mode;
    begin
      pll_capable = (mode == `CSPT_MODE_EXTERNAL_CLOCK_MODE_WITH_PLL) || (mode == `CSPT_MODE_CRYSTAL_MODE_WITH_PLL) ||
                    (mode == `CSPT_MODE_IOPLLO) || (mode == `CSPT_MODE_IOPLL);
    end
  endfunction

  function is_ext_clk;
    input [2:0] mode;
    begin
      is_ext_clk = (mode == `CSPT_MODE_EC) || (mode == `CSPT_MODE_EXTERNAL_CLOCK_MODE_WITH_PLL);
    end
  endfunction

  function is_internal;
    input [2:0] mode;
    begin
      is_internal = (mode[2] == 1'b0);
    end
  endfunction

  // Postscaler log2 ratio from the 8 MHz main output
  function [3:0] post_shift;
    input [2:0] sel;
    begin
      case (sel)
        3'h1:    post_shift = 4'h6;
        3'h2:    post_shift = 4'h5;
        3'h3:    post_shift = 4'h4;
        3'h4:    post_shift = 4'h3;
        3'h5:    post_shift = 4'h2;
        3'h6:    post_shift = 4'h1;
        default: post_shift = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = wb_req & wb_we_i & wb_sel_i[0];

  always @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h0000_0000;
      oscillator_tuning <= `CSPT_TUNE_RST;
      clock_ctrl        <= `CSPT_CTRL_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wr_stb && wb_adr_i == `CSPT_ADDR_TUNE)
        oscillator_tuning <= wb_dat_i[7:0];
      if (wr_stb && wb_adr_i == `CSPT_ADDR_CTRL)
        clock_ctrl <= wb_dat_i[7:0];
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `CSPT_ADDR_TUNE: wb_dat_o <= {24'h000000, oscillator_tuning};
          `CSPT_ADDR_CTRL: wb_dat_o <= {24'h000000, clock_ctrl};
          `CSPT_ADDR_STAT: wb_dat_o <= {24'h000000, 1'b0, rc_osc_run, pll_run,
                                        pll_sel, ext_clock_ready, pll_state};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables and trim
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      rc_osc_run      <= 1'b0;
      osc_8m_run      <= 1'b0;
      osc_8m_trim     <= 6'h00;
      ext_clock_ready <= 1'b0;
    end else begin
      rc_osc_run  <= (system_clock_source_select != `CSPT_SCS_PRI && internal_freq_select == `CSPT_INTERNAL_FREQ_SELECT_31K && !lfsrc) |
                     pwrt_en | fscm_en | wdt_en | two_speed_en;
      osc_8m_run  <= is_internal(osc_mode_cfg) | (system_clock_source_select != `CSPT_SCS_PRI);
      // Trim goes to the 8 MHz oscillator only; field is two's complement
      osc_8m_trim <= oscillator_tuning[5:0];
      ext_clock_ready <= is_ext_clk(osc_mode_cfg);
    end
  end

  // ----------------------------------------------------------------
  // PLL enable and lock sequencing
  // ----------------------------------------------------------------
  always @* begin
    next_pll_state = pll_state;
    case (pll_state)
      ST_BYPASS: if (pll_run) next_pll_state = ST_LOCK;
      ST_LOCK: begin
        if (!pll_run)
          next_pll_state = ST_BYPASS;
        else if (pll_locked && lock_cnt == 32'h0000_0000)
          next_pll_state = ST_PLL;
      end
      ST_PLL:  if (!pll_run) next_pll_state = ST_BYPASS;
      default: next_pll_state = ST_BYPASS;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      pll_run   <= 1'b0;
      pll_state <= ST_BYPASS;
      lock_cnt  <= 32'h0000_0000;
    end else begin
      // PLL off in non-capable modes or when not on primary source
      pll_run   <= pll_capable(osc_mode_cfg) & pll_bit &
                   (system_clock_source_select == `CSPT_SCS_PRI);
      pll_state <= next_pll_state;
      if (pll_state == ST_BYPASS)
        lock_cnt <= LOCK_CYCLES; // Wait bound covers the worst lock time
      else if (lock_cnt != 32'h0000_0000)
        lock_cnt <= lock_cnt - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // PLL reference prescaler: divide by 12,10,6,5,4,3,2,1
  // ----------------------------------------------------------------
  reg [3:0] pre_ratio;
  reg [3:0] pre_div;
  always @* begin
    case (pll_prescale_cfg)
      3'h0:    pre_ratio = 4'hC;
      3'h1:    pre_ratio = 4'hA;
      3'h2:    pre_ratio = 4'h6;
      3'h3:    pre_ratio = 4'h5;
      3'h4:    pre_ratio = 4'h4;
      3'h5:    pre_ratio = 4'h3;
      3'h6:    pre_ratio = 4'h2;
      default: pre_ratio = 4'h1;
    endcase
  end

  wire pri_tick = is_internal(osc_mode_cfg) ? osc_8m_tick : oscillator_input_pin;

  always @(posedge clk) begin
    if (!rstn) begin
      pre_div      <= 4'h0;
      pll_ref_tick <= 1'b0;
    end else begin
      pll_ref_tick <= 1'b0;
      if (pri_tick) begin
        if (pre_div + 4'h1 >= pre_ratio) begin
          pre_div      <= 4'h0;
          pll_ref_tick <= pll_run;
        end else begin
          pre_div <= pre_div + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal postscaler and low-frequency source
  // ----------------------------------------------------------------
  reg [7:0] post_cnt;
  always @(posedge clk) begin
    if (!rstn) begin
      post_cnt  <= 8'h00;
      post_tick <= 1'b0;
    end else begin
      post_tick <= 1'b0;
      if (internal_freq_select == `CSPT_INTERNAL_FREQ_SELECT_31K) begin
        if (lfsrc) begin
          if (osc_8m_tick) begin
            post_cnt  <= post_cnt + 8'h01;
            post_tick <= (post_cnt == `CSPT_DIV256);
          end
        end else begin
          post_tick <= rc_31k_tick;
        end
      end else if (internal_freq_select == `CSPT_INTERNAL_FREQ_SELECT_8M) begin
        post_tick <= osc_8m_tick;
      end else if (osc_8m_tick) begin
        post_cnt  <= post_cnt + 8'h01;
        post_tick <= ((post_cnt & ((8'h01 << post_shift(internal_freq_select)) - 8'h01)) ==
                      ((8'h01 << post_shift(internal_freq_select)) - 8'h01));
      end
    end
  end

  // ----------------------------------------------------------------
  // Source mux; switching only between whole source ticks
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      scs_act  <= `CSPT_SCS_PRI;
      pll_sel  <= 1'b0;
      src_tick <= 1'b0;
    end else begin
      // Selects update on core_tick, which the divider raises every clock cycle
      if (core_tick) begin
        scs_act  <= system_clock_source_select;
        pll_sel  <= (pll_state == ST_PLL);
      end
      case (scs_act)
        `CSPT_SCS_PRI: src_tick <= pll_sel ? pll_96m_tick : pri_tick;
        `CSPT_SCS_SEC: src_tick <= sec_osc_tick;
        default:       src_tick <= post_tick;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core divider 1, 2, 3, 6; PLL path adds the fixed divide by two
  // ----------------------------------------------------------------
  always @* begin
    case (core_clock_divider_cfg)
      2'h3:    core_ratio = 8'h00;
      2'h2:    core_ratio = 8'h01;
      2'h1:    core_ratio = 8'h02;
      default: core_ratio = 8'h05;
    endcase
    if (pll_sel && scs_act == `CSPT_SCS_PRI)
      core_ratio = {core_ratio[6:0], 1'b1};
  end

  reg [7:0] src_seen;
  always @(posedge clk) begin
    if (!rstn) begin
      src_seen    <= 8'h00;
      core_clk_en <= 1'b0;
    end else begin
      core_clk_en <= 1'b0;
      if (src_tick) begin
        if (src_seen >= core_ratio) begin
          src_seen    <= 8'h00;
          core_clk_en <= 1'b1;
        end else begin
          src_seen <= src_seen + 8'h01;
        end
      end
    end
  end

  cspt_clkdiv #(
    .W (8)
  ) u_tick (
    .clk      (clk),
    .rstn     (rstn),
    .ratio_m1 (8'h00),
    .tick     (core_tick)
  );

  // ----------------------------------------------------------------
  // Oscillator output pin: source over four in external clock modes
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      out_cnt               <= 2'h0;
      oscillator_output_pin <= 1'b0;
      oscillator_output_oe  <= 1'b0;
    end else begin
      oscillator_output_oe <= is_ext_clk(osc_mode_cfg) |
                              (osc_mode_cfg == `CSPT_MODE_IOPLLO) |
                              (osc_mode_cfg == `CSPT_MODE_IOO);
      if (osc_mode_cfg == `CSPT_MODE_EXTERNAL_CLOCK_MODE_WITH_PLL && pll_sel ? pll_96m_tick : pri_tick) begin
        out_cnt <= out_cnt + 2'h1;
        if (out_cnt[0])
          oscillator_output_pin <= ~out_cnt[1];
      end
    end
  end

endmodule

`default_nettype wire

// [bench/cspt_assertions.sv]
// Port checker for the clock source, PLL and tuning block.
// Assumes bind onto cspt_top; config inputs change only under reset.
`timescale 1ns/10ps
`default_nettype none
`include "cspt_defs.vh"
module cspt_assertions (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [13:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  osc_mode_cfg,
  input wire logic [1:0]  core_clock_divider_cfg,
  input wire logic        pwrt_en,
  input wire logic        fscm_en,
  input wire logic        wdt_en,
  input wire logic        two_speed_en,
  input wire logic        core_clk_en,
  input wire logic        pll_run,
  input wire logic        rc_osc_run,
  input wire logic [5:0]  osc_8m_trim,
  input wire logic        ext_clock_ready,
  input wire logic        oscillator_output_oe
);
  // ----
  // Helpers
  // ----
  logic       cap;
  logic       ec;
  logic       feat;
  logic       wr_tune;
  logic [5:0] wd;
  assign cap  = (osc_mode_cfg == 3'h7) || (osc_mode_cfg == 3'h5) ||
                (osc_mode_cfg == 3'h3) || (osc_mode_cfg == 3'h2);
  assign ec   = (osc_mode_cfg[2:1] == 2'h3);
  assign feat = pwrt_en | fscm_en | wdt_en | two_speed_en;
  assign wr_tune = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0] &
                   (wb_adr_i == `CSPT_ADDR_TUNE);
  assign wd = wb_dat_i[5:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----
  // Properties
  // ----
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_take; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  property p_rd_upper; (wb_ack_o && !wb_we_i) |-> wb_dat_o[31:8] == 24'h0; endproperty
  property p_pll_off; (!cap) [*2] |-> !pll_run; endproperty
  property p_pll_cap; pll_run |-> cap; endproperty
  property p_ext_rdy; ec [*3] |-> ext_clock_ready; endproperty
  property p_oe; ec [*3] |-> oscillator_output_oe; endproperty
  property p_rc; feat [*3] |-> rc_osc_run; endproperty
  property p_trim; wr_tune |-> ##2 (osc_8m_trim == $past(wd, 2)); endproperty
  property p_core_gap;
    (core_clk_en && core_clock_divider_cfg != 2'h3) |=> !core_clk_en;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held over one cycle");
  a_ack_take: assert property (p_ack_take) else $error("request not acknowledged");
  a_rd_upper: assert property (p_rd_upper) else $error("read upper bits not zero");
  a_pll_off: assert property (p_pll_off) else $error("pll runs in plain mode");
  a_pll_cap: assert property (p_pll_cap) else $error("pll runs in wrong mode");
  a_ext_rdy: assert property (p_ext_rdy) else $error("external clock not ready");
  a_oe: assert property (p_oe) else $error("output pin not driven");
  a_rc: assert property (p_rc) else $error("rc oscillator stopped");
  a_trim: assert property (p_trim) else $error("trim not updated");
  a_core_gap: assert property (p_core_gap) else $error("core pulse too close");
  c_wr_tune: cover property (wr_tune);
  c_pll: cover property (pll_run);
  c_rc: cover property (feat ##1 rc_osc_run);
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the clock source, PLL and tuning block.
// Assumes cspt_defs.vh on the include path; drives ticks itself.
`timescale 1ns/10ps
`default_nettype none
`include "cspt_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic        clk, rstn, we, stb, cyc, ack, in_tk, t8, trc, tsec, t96, lock;
  logic        pin, oe, cen, prun, pref, rcr, r8, erdy;
  logic [13:0] adr;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0]  sel, feat;
  logic [2:0]  mode, pre;
  logic [1:0]  cdiv;
  logic [5:0]  trim, lk;
  int          n_fail, checks, cyc_n, n_cen, n_ref, n_tog, i;
  int          ratio[8] = '{12, 10, 6, 5, 4, 3, 2, 1};
  int          ndiv[4] = '{6, 3, 2, 1};
  cspt_top #(.LOCK_CYCLES(20)) uut (.clk(clk), .rstn(rstn), .wb_adr_i(adr),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel),
    .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .osc_mode_cfg(mode),
    .pll_prescale_cfg(pre), .core_clock_divider_cfg(cdiv), .pwrt_en(feat[0]),
    .fscm_en(feat[1]), .wdt_en(feat[2]), .two_speed_en(feat[3]),
    .oscillator_input_pin(in_tk), .osc_8m_tick(t8), .rc_31k_tick(trc),
    .sec_osc_tick(tsec), .pll_96m_tick(t96), .pll_locked(lock),
    .oscillator_output_pin(pin), .oscillator_output_oe(oe), .core_clk_en(cen),
    .pll_run(prun), .pll_ref_tick(pref), .rc_osc_run(rcr), .osc_8m_run(r8),
    .osc_8m_trim(trim), .ext_clock_ready(erdy));
  // ----
  // Clock, oscillator ticks, lock after seven cycles of run
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    in_tk <= (cyc_n % 3) == 0;
    t8    <= (cyc_n % 4) == 0;
    trc   <= (cyc_n % 16) == 0;
    tsec  <= (cyc_n % 32) == 0;
    t96   <= (cyc_n % 8) != 7;
    lk    <= {lk[4:0], prun};
    lock  <= lk[5] & prun;
  end
  // ----
  // Tasks
  // ----
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] m, input logic [2:0] p, input logic [1:0] d);
    rstn <= 1'b0; mode <= m; pre <= p; cdiv <= d;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [13:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    int k;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {24'h0, d}; sel <= s;
    k = 0;
    // Ack and read data are read at the edge, before that edge updates them
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED ack exp 1 got %b", ack);
      end_sim;
    end else begin
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 4'hF);
    `CHK("read data", {24'h0, e}, q)
  endtask
  task automatic measure(input int n);
    logic p;
    n_cen = 0; n_ref = 0; n_tog = 0; p = pin;
    repeat (n) begin
      @(negedge clk);
      n_cen += cen; n_ref += pref; n_tog += (pin !== p); p = pin;
    end
    // Next request starts just after a rising edge
    @(posedge clk);
  endtask
  task automatic near(input string nm, input int e, input int g, input int t);
    `CHK(nm, 1'b1, (g >= e - t && g <= e + t))
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    rstn = 1'b0; we = 1'b0; stb = 1'b0; cyc = 1'b0; adr = 14'h0; dat_i = 32'h0;
    sel = 4'h0; feat = 4'h0; mode = 3'h0; pre = 3'h0; cdiv = 2'h3; cyc_n = 0;
    in_tk = 1'b0; t8 = 1'b0; trc = 1'b0; tsec = 1'b0; t96 = 1'b0; lock = 1'b0;
    lk = 6'h00; n_fail = 0; checks = 0;
    @(posedge clk);
    do_reset(`CSPT_MODE_IO, 3'h0, 2'h3);
    rd(`CSPT_ADDR_TUNE, `CSPT_TUNE_RST);
    rd(`CSPT_ADDR_CTRL, `CSPT_CTRL_RST);
    rd(14'h0010, 8'h00);
    wb(1'b1, `CSPT_ADDR_TUNE, 8'h1F, 4'h1);
    `CHK("trim max", `CSPT_TUNE_MAX, trim)
    wb(1'b1, `CSPT_ADDR_TUNE, 8'hA0, 4'h1);
    `CHK("trim min", `CSPT_TUNE_MIN, trim)
    wb(1'b1, `CSPT_ADDR_TUNE, 8'h05, 4'h0);
    rd(`CSPT_ADDR_TUNE, 8'hA0);
    for (i = 0; i < 4; i++) begin
      feat <= 4'h1 << i;
      repeat (4) @(posedge clk);
      `CHK("rc run feature", 1'b1, rcr)
    end
    feat <= 4'h0;
    // Postscaled internal source; 8 MHz ticks every 4 cycles
    for (i = 0; i < 9; i++) begin
      wb(1'b1, `CSPT_ADDR_TUNE, (i == 8) ? 8'h80 : 8'h00, 4'h1);
      wb(1'b1, `CSPT_ADDR_CTRL, {1'b0, (i < 8) ? i[2:0] : 3'h0, 4'h2}, 4'h1);
      measure(2048);
      if (i == 0) `CHK("rc run select", 1'b1, rcr)
      near("core rate", (i == 0) ? 128 : (i == 8) ? 2 : (i == 7) ? 512 :
           512 >> (7 - i), n_cen, 1);
    end
    for (i = 0; i < 8; i++) begin
      do_reset(i[2:0], 3'h7, 2'h3);
      `CHK("ext ready", (i >= 6), erdy)
      `CHK("out enable", (i == 7 || i == 6 || i == 3 || i == 1), oe)
      `CHK("8m run", (i < 4), r8)
      wb(1'b1, `CSPT_ADDR_TUNE, 8'h40, 4'h1);
      repeat (3) @(posedge clk);
      `CHK("pll run", (i == 7 || i == 5 || i == 3 || i == 2), prun)
    end
    for (i = 0; i < 8; i++) begin
      do_reset(`CSPT_MODE_EXTERNAL_CLOCK_MODE_WITH_PLL, i[2:0], 2'h3);
      wb(1'b1, `CSPT_ADDR_TUNE, 8'h40, 4'h1);
      measure(18);
      `CHK("bypass toggles", 1'b1, (n_tog <= 4))
      repeat (40) @(posedge clk);
      measure(600);
      near("ref ticks", 200 / ratio[i], n_ref, 1);
      near("pll pin", 262, n_tog, 2);
      near("pll core", 262, n_cen, 2);
      rd(`CSPT_ADDR_STAT, 8'h3C);
    end
    for (i = 0; i < 4; i++) begin
      do_reset(`CSPT_MODE_EC, 3'h0, i[1:0]);
      measure(600);
      near("core div", 200 / ndiv[i], n_cen, 1);
      near("ec pin", 100, n_tog, 1);
    end
    end_sim;
  end
endmodule
bind cspt_top cspt_assertions u_chk (.clk(clk), .rstn(rstn), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
  .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .osc_mode_cfg(osc_mode_cfg), .core_clock_divider_cfg(core_clock_divider_cfg),
  .pwrt_en(pwrt_en), .fscm_en(fscm_en), .wdt_en(wdt_en), .two_speed_en(two_speed_en),
  .core_clk_en(core_clk_en), .pll_run(pll_run), .rc_osc_run(rc_osc_run),
  .osc_8m_trim(osc_8m_trim), .ext_clock_ready(ext_clock_ready),
  .oscillator_output_oe(oscillator_output_oe));
`default_nettype wire
